/* File: rtl/fmpg_bank.sv */
// Fault-mask and output-one power-good tree register bank.
// Assumes a simple synchronous byte register port and factory power-up values on pins.
//
// Overview of operation
// RQ1: Software writes zero to reserved bit 6 of the second fault mask.
// RQ2: Software writes one to reserved bit 5 of the second fault mask.
// RQ3: A set fault mask bit blocks shutdown from that rail; clear lets it through.
// RQ4: Fault mask bit 4 covers linear A1, bit 3 the termination regulator.
// RQ5: Fault mask bits 2, 1, 0 cover switch B2, switch B1, linear A3.
// RQ6: Tree mask bit zero includes a member; one excludes and ignores it.
// RQ7: Tree mask A bits 7, 6 cover linear A2, switch A1; bits 5..0 step-downs 6..1.
// RQ8: Tree mask B bits 7, 6, 5, 4 cover control inputs 5, 4, 2, 1.
// RQ9: Tree mask B bits 3..0 cover termination, shared rail, switch B1, linear A3.
// RQ10: The shared bit applies to whichever rail the factory selected for it.
// RQ11: Output one follows the tree unless set up as a software output.
// RQ12: The tree is good only when every included member is good.
// RQ13: Any unmasked fault on a covered rail starts the shutdown sequence.
`timescale 1ns/1ps
`include "fmpg_regs.svh"
module fmpg_bank
  import fmpg_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // Register port.
  input wire fmpg_req_t req_i,
  output logic [7:0] rdata_o,
  // Factory configuration.
  input wire logic [7:0] fault_mask2_init_i,
  input wire logic [7:0] tree_mask_a_init_i,
  input wire logic [7:0] tree_mask_b_init_i,
  input wire logic shared_is_switch_i,
  input wire logic out_one_sw_mode_i,
  input wire logic out_one_sw_level_i,
  // Rail status.
  input wire fmpg_good_t good_i,
  input wire fmpg_fault_t fault_i,
  // Results.
  output logic shutdown_req_o,
  output logic general_output_one_o
);
  logic rst_meta_reg;
  logic rst_sync_reg;
  logic init_done_reg;
  fmpg_state_t state_reg;
  fmpg_state_t state_next;
  logic [15:0] members;
  logic [15:0] masks;
  logic shared_good;
  logic tree_good;
  logic [4:0] fault_vec;
  logic [4:0] fault_live;

  // Clears the read-only top bit of the second fault mask, so neither the factory load nor a write can set it.
  function automatic logic [7:0] fm2_clean(input logic [7:0] value);
    logic [7:0] result;
    result = value;
    result[`FMPG_FM2_RSV7] = 1'b0;
    return result;
  endfunction

  // Reset release goes through two flip-flops so the release is clean.
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // The shared tree position follows the factory rail selection.
  assign shared_good = shared_is_switch_i ? good_i.switch_b_two : good_i.linear_a_one; // RQ10
  // Member order matches the two tree mask registers, A high, B low.
  assign members = {good_i.linear_a_two, good_i.switch_a_one, good_i.stepdown,
                    good_i.control_in, good_i.termination, shared_good,
                    good_i.switch_b_one, good_i.linear_a_three}; // RQ7 RQ8 RQ9
  assign masks = {state_reg.tree_mask_a_reg, state_reg.tree_mask_b_reg};

  fmpg_tree #(
    .WIDTH(16)
  ) u_tree (
    .member_i(members),
    .mask_i(masks),
    .good_o(tree_good)
  );

  // Fault flags in the bit order of the second fault mask.
  assign fault_vec = {fault_i.linear_a_one, fault_i.termination, fault_i.switch_b_two,
                      fault_i.switch_b_one, fault_i.linear_a_three}; // RQ4 RQ5
  // Faults whose mask bit is clear are the ones that may stop the device.
  assign fault_live = fault_vec & ~state_reg.fault_mask2_reg[`FMPG_FM2_LINEAR_A1:`FMPG_FM2_LINEAR_A3]; // RQ3

  // Register update, readback, fault gating and output selection.
  always_comb
  begin
    state_next = state_reg;
    state_next.rdata_reg = `FMPG_BYTE_ZERO;
    if (!init_done_reg)
    begin
      // Factory values are taken once, after reset release.
      state_next.fault_mask2_reg = fm2_clean(fault_mask2_init_i);
      state_next.tree_mask_a_reg = tree_mask_a_init_i;
      state_next.tree_mask_b_reg = tree_mask_b_init_i;
    end
    else if (req_i.wr)
    begin
      unique case (req_i.addr)
        `FMPG_OFS_FAULT_MASK2:
        begin
          // Bit 7 is read-only and reads as zero; software is trusted to keep bits 6 and 5 as required.
          state_next.fault_mask2_reg = fm2_clean(req_i.wdata); // RQ1 RQ2
        end
        `FMPG_OFS_TREE_MASK_A: state_next.tree_mask_a_reg = req_i.wdata;
        `FMPG_OFS_TREE_MASK_B: state_next.tree_mask_b_reg = req_i.wdata;
        default: state_next.fault_mask2_reg = state_reg.fault_mask2_reg;
      endcase
    end
    if (req_i.rd)
    begin
      unique case (req_i.addr)
        `FMPG_OFS_FAULT_MASK2: state_next.rdata_reg = state_reg.fault_mask2_reg;
        `FMPG_OFS_TREE_MASK_A: state_next.rdata_reg = state_reg.tree_mask_a_reg;
        `FMPG_OFS_TREE_MASK_B: state_next.rdata_reg = state_reg.tree_mask_b_reg;
        default: state_next.rdata_reg = `FMPG_BYTE_ZERO;
      endcase
    end
    // Shutdown request is sticky until reset; the sequence must not be aborted mid-way.
    // Faults are weighed only once the factory masks are in, as the cleared masks before that mean nothing.
    state_next.shutdown_reg = state_reg.shutdown_reg | (init_done_reg & (|fault_live)); // RQ3 RQ13
    state_next.out_one_reg = out_one_sw_mode_i ? out_one_sw_level_i : tree_good; // RQ11
  end

  // One register for the whole state.
  always_ff @(posedge core_clk_i or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
    begin
      state_reg <= '0;
      init_done_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      init_done_reg <= 1'b1;
    end
  end

  assign rdata_o = state_reg.rdata_reg;
  assign shutdown_req_o = state_reg.shutdown_reg;
  assign general_output_one_o = state_reg.out_one_reg;

  // An unmasked fault raises the shutdown request on the next edge.
  AST_FAULT_SHUTDOWN: assert property (@(posedge core_clk_i) disable iff (!rst_sync_reg) // RQ13
    (init_done_reg && |(fault_vec & ~state_reg.fault_mask2_reg[4:0])) |=> shutdown_req_o)
    else $error("Unmasked fault did not raise shutdown.");

  // Masked-only faults never start a shutdown from a clean state.
  AST_MASKED_FAULT: assert property (@(posedge core_clk_i) disable iff (!rst_sync_reg) // RQ3
    (!shutdown_req_o && !(|(fault_vec & ~state_reg.fault_mask2_reg[4:0]))) |=> !shutdown_req_o)
    else $error("Masked fault started shutdown.");

  // Linear A1 fault with bit 4 clear must shut down.
  AST_LINEAR_A1: assert property (@(posedge core_clk_i) disable iff (!rst_sync_reg) // RQ4
    (init_done_reg && fault_i.linear_a_one && !state_reg.fault_mask2_reg[`FMPG_FM2_LINEAR_A1])
    |=> shutdown_req_o)
    else $error("Linear A1 fault lost.");

  // Switch B2 fault with bit 2 clear must shut down.
  AST_SWITCH_B2: assert property (@(posedge core_clk_i) disable iff (!rst_sync_reg) // RQ5
    (init_done_reg && fault_i.switch_b_two && !state_reg.fault_mask2_reg[`FMPG_FM2_SWITCH_B2])
    |=> shutdown_req_o)
    else $error("Switch B2 fault lost.");

  // With all members masked the tree reads good.
  AST_ALL_MASKED: assert property (@(posedge core_clk_i) disable iff (!rst_sync_reg) // RQ6
    (!out_one_sw_mode_i && (&masks)) |=> general_output_one_o)
    else $error("Fully masked tree not good.");

  // An included step-down rail that is bad pulls the output low.
  AST_STEPDOWN_ONE: assert property (@(posedge core_clk_i) disable iff (!rst_sync_reg) // RQ7
    (!out_one_sw_mode_i && !good_i.stepdown[0] && !state_reg.tree_mask_a_reg[`FMPG_TA_STEPDOWN_ONE])
    |=> !general_output_one_o)
    else $error("Step-down one not in tree.");

  // An included control input that is low pulls the output low.
  AST_CONTROL_FIVE: assert property (@(posedge core_clk_i) disable iff (!rst_sync_reg) // RQ8
    (!out_one_sw_mode_i && !good_i.control_in[3] && !state_reg.tree_mask_b_reg[`FMPG_TB_CTL_FIVE])
    |=> !general_output_one_o)
    else $error("Control input five not in tree.");

  // The shared member follows the factory selection.
  AST_SHARED: assert property (@(posedge core_clk_i) disable iff (!rst_sync_reg) // RQ10
    (!out_one_sw_mode_i && !state_reg.tree_mask_b_reg[`FMPG_TB_SHARED] && shared_is_switch_i
     && !good_i.switch_b_two) |=> !general_output_one_o)
    else $error("Shared member ignores selection.");

  // Software mode drives the programmed level.
  AST_SW_MODE: assert property (@(posedge core_clk_i) disable iff (!rst_sync_reg) // RQ11
    out_one_sw_mode_i |=> (general_output_one_o == $past(out_one_sw_level_i)))
    else $error("Software level not driven.");

  // Linear A1 stands in the shared position when the factory did not pick switch B2.
  AST_SHARED_LINEAR: assert property (@(posedge core_clk_i) disable iff (!rst_sync_reg) // RQ10
    (!out_one_sw_mode_i && !state_reg.tree_mask_b_reg[`FMPG_TB_SHARED] && !shared_is_switch_i
     && !good_i.linear_a_one) |=> !general_output_one_o)
    else $error("Shared member ignores linear A1.");

  // An included termination regulator that is bad pulls the output low.
  AST_TERMINATION: assert property (@(posedge core_clk_i) disable iff (!rst_sync_reg) // RQ9
    (!out_one_sw_mode_i && !good_i.termination && !state_reg.tree_mask_b_reg[`FMPG_TB_TERM])
    |=> !general_output_one_o)
    else $error("Termination regulator not in tree.");

  // Once raised, the shutdown request holds until the next reset.
  AST_SHUTDOWN_HOLD: assert property (@(posedge core_clk_i) disable iff (!rst_sync_reg) // RQ13
    shutdown_req_o |=> shutdown_req_o)
    else $error("Shutdown request dropped before reset.");
endmodule

/* File: rtl/fmpg_pkg.sv */
// Types shared by the fault-mask and power-good tree bank.
// Assumes nothing beyond the register header.
package fmpg_pkg;
  // Register port request.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fmpg_req_t;
  // Power-good inputs of the rails that can join the output-one tree.
  typedef struct packed {
    logic linear_a_two;
    logic switch_a_one;
    logic [5:0] stepdown;
    logic [3:0] control_in;
    logic termination;
    logic switch_b_two;
    logic linear_a_one;
    logic switch_b_one;
    logic linear_a_three;
  } fmpg_good_t;
  // Fault flags of the rails covered by the second fault mask.
  typedef struct packed {
    logic linear_a_one;
    logic termination;
    logic switch_b_two;
    logic switch_b_one;
    logic linear_a_three;
  } fmpg_fault_t;
  // Whole register state.
  typedef struct packed {
    logic [7:0] fault_mask2_reg;
    logic [7:0] tree_mask_a_reg;
    logic [7:0] tree_mask_b_reg;
    logic [7:0] rdata_reg;
    logic shutdown_reg;
    logic out_one_reg;
  } fmpg_state_t;
endpackage

/* File: rtl/fmpg_regs.svh */
// Register offsets, field positions and reserved-bit values of the fault-mask and power-good tree bank.
// Assumes an 8-bit register port with byte offsets as printed; included by bare name.
`ifndef FMPG_REGS_SVH
`define FMPG_REGS_SVH
`define FMPG_OFS_FAULT_MASK2 8'ha3
`define FMPG_OFS_TREE_MASK_A 8'ha4
`define FMPG_OFS_TREE_MASK_B 8'ha5
`define FMPG_FM2_RSV7 7
`define FMPG_FM2_RSV6 6
`define FMPG_FM2_RSV5 5
`define FMPG_FM2_LINEAR_A1 4
`define FMPG_FM2_TERM 3
`define FMPG_FM2_SWITCH_B2 2
`define FMPG_FM2_SWITCH_B1 1
`define FMPG_FM2_LINEAR_A3 0
`define FMPG_TB_CTL_LSB 4
`define FMPG_TB_TERM 3
`define FMPG_TB_SHARED 2
`define FMPG_TB_SWITCH_B1 1
`define FMPG_TB_LINEAR_A3 0
`define FMPG_TA_STEPDOWN_ONE 0
`define FMPG_TB_CTL_FIVE 7
`define FMPG_FM2_RSV_MASK 8'he0
`define FMPG_FM2_RSV_VALUE 8'h20
`define FMPG_BYTE_ZERO 8'h00
`endif

/* File: rtl/fmpg_tree.sv */
// Combines the members of a power-good tree under a mask.
// Assumes member states and masks are synchronous to the core clock.
`timescale 1ns/1ps
module fmpg_tree
  import fmpg_pkg::*;
#(
  parameter int WIDTH = 16
)
(
  // Members and their masks.
  input wire logic [WIDTH-1:0] member_i,
  input wire logic [WIDTH-1:0] mask_i,
  // Result.
  output logic good_o
);
  // A masked member is forced good so it cannot pull the tree low.
  assign good_o = &(member_i | mask_i); // RQ6 RQ12
endmodule

/* File: tb/fmpg_bank_test.sv */
// Self-checking bench for the fault-mask and power-good tree bank.
// Assumes the register header and package of the bank and the host model.
`timescale 1ns/1ps
`include "fmpg_regs.svh"
module fmpg_bank_test;
  import fmpg_pkg::*;
  logic core_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  fmpg_req_t req = '0;
  fmpg_good_t good = '1;
  fmpg_fault_t fault = '0;
  logic sel = 1'b0;
  logic swm = 1'b0;
  logic swl = 1'b0;
  logic [7:0] rdata;
  logic shut;
  logic out1;
  logic seen;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int m;

  // Factory values are tied, so only the power-up load is seen through them.
  fmpg_bank i_fmpg_bank (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .req_i(req), .rdata_o(rdata),
    .fault_mask2_init_i(8'ha5), .tree_mask_a_init_i(8'h5a), .tree_mask_b_init_i(8'hc3),
    .shared_is_switch_i(sel), .out_one_sw_mode_i(swm), .out_one_sw_level_i(swl),
    .good_i(good), .fault_i(fault), .shutdown_req_o(shut), .general_output_one_o(out1));
  fmpg_host i_fmpg_host (.core_clk_i(core_clk_i), .pin_i(out1), .seen_o(seen));

  // Clock at 25 MHz.
  initial
  begin
    forever #20 core_clk_i = ~core_clk_i;
  end

  // Advance to just after a rising edge, where inputs are changed.
  task step(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  // Compare and count; an unknown never matches.
  task chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // A write strobe lasts one cycle, then one idle edge before the next request.
  task wr(input logic [7:0] a, input logic [7:0] d);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    step(1);
    req = '0;
    step(1);
  endtask

  // Read data is valid for the one cycle after the strobe.
  task rd(input logic [7:0] a, input logic [7:0] exp);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    step(1);
    req = '0;
    chk(rdata, exp);
    step(1);
  endtask

  // Three cycles of reset, then the sync and factory load before the first request.
  task rst;
    rstn_i = 1'b0;
    step(3);
    rstn_i = 1'b1;
    step(3);
  endtask

  // Expected tree result: a member counts only while its mask bit is clear.
  function logic exp_tree(input fmpg_good_t g, input logic [15:0] mk, input logic s);
    logic [16:0] v;
    v = g;
    return &({v[16:9], v[8:4], s ? v[3] : v[2], v[1:0]} | mk);
  endfunction

  task give_verdict;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // A hang is cut short well beyond the few hundred cycles the tests need.
  always @(posedge core_clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_errors++;
      give_verdict;
    end
  end

  initial
  begin
    rst;
    rd(`FMPG_OFS_FAULT_MASK2, 8'h25);
    rd(`FMPG_OFS_TREE_MASK_A, 8'h5a);
    rd(`FMPG_OFS_TREE_MASK_B, 8'hc3);
    rd(8'ha6, 8'h00);
    wr(8'ha6, 8'h11);
    rd(8'ha6, 8'h00);
    wr(`FMPG_OFS_FAULT_MASK2, 8'ha0);
    rd(`FMPG_OFS_FAULT_MASK2, 8'h20);
    // One low member at a time, masked alone and then left alone in the tree.
    for (int s = 0; s < 2; s++)
    begin
      sel = s[0];
      for (int i = 0; i < 17; i++)
      begin
        good = fmpg_good_t'(~(17'h1 << i));
        m = (i >= 4) ? i - 1 : ((i >= 2) ? 2 : i);
        wr(`FMPG_OFS_TREE_MASK_A, 8'h01 << (m - 8));
        wr(`FMPG_OFS_TREE_MASK_B, 8'h01 << m);
        step(2);
        chk(seen, exp_tree(good, 16'h1 << m, sel));
        wr(`FMPG_OFS_TREE_MASK_A, ~(8'h01 << (m - 8)));
        wr(`FMPG_OFS_TREE_MASK_B, ~(8'h01 << m));
        rd(`FMPG_OFS_TREE_MASK_B, ~(8'h01 << m));
        chk(seen, exp_tree(good, ~(16'h1 << m), sel));
      end
    end
    // Every member masked: the tree reads good although one rail is still bad.
    wr(`FMPG_OFS_TREE_MASK_A, 8'hff);
    wr(`FMPG_OFS_TREE_MASK_B, 8'hff);
    step(2);
    chk(seen, 8'h01);
    // Software mode overrides the tree with the pin level.
    swm = 1'b1;
    for (int l = 0; l < 2; l++)
    begin
      swl = l[0];
      step(2);
      chk(seen, l[7:0]);
    end
    swm = 1'b0;
    // Each covered rail, masked and then unmasked with every other rail masked.
    for (int j = 0; j < 5; j++)
    begin
      rst;
      wr(`FMPG_OFS_FAULT_MASK2, 8'h3f);
      fault = fmpg_fault_t'(5'h1 << j);
      step(2);
      chk(shut, 8'h00);
      fault = '0;
      wr(`FMPG_OFS_FAULT_MASK2, 8'h3f ^ (8'h01 << j));
      fault = fmpg_fault_t'(5'h1 << j);
      step(2);
      chk(shut, 8'h01);
      fault = '0;
    end
    give_verdict;
  end
endmodule

/* File: tb/fmpg_host.sv */
// Host model that watches the output-one power-good pin.
// Assumes the pin is a level synchronous to the core clock.
`timescale 1ns/1ps
module fmpg_host (
  // Clock and pin.
  input wire logic core_clk_i,
  input wire logic pin_i,
  // Level as the host saw it.
  output logic seen_o
);
  // The host samples once a cycle, so a level shows here one edge late.
  always_ff @(posedge core_clk_i)
  begin
    seen_o <= pin_i;
  end
endmodule
